/* pkg/arc_pkg.sv */
// Purpose: Constants, register map and types for the audio reciprocal counter control.
// Assumes: 10 MHz clock, APB slave with 32-bit data.
// Notes:   Offsets and field positions are named here and nowhere else.
package arc_pkg;
   // Clock and gate timing.
   localparam int unsigned CLK_HZ          = 10000000;
   localparam int unsigned GATE_MIN_MS     = 100;
   localparam int unsigned GATE_MIN_CYC    = (CLK_HZ / 1000) * GATE_MIN_MS;
   localparam int unsigned MIN_AUDIO_HZ    = 20;
   localparam int unsigned MAX_AUDIO_HZ    = 250000;
   localparam int unsigned FINE_LO_HZ      = 100000;
   // Longest gate: minimum gate plus two full periods of the slowest audio.
   localparam int unsigned GATE_MAX_CYC    = GATE_MIN_CYC + 2 * (CLK_HZ / MIN_AUDIO_HZ);
   localparam int unsigned CNT_W           = 32;

   // Register byte offsets.
   localparam logic [7:0] OFS_CMD     = 8'h00;
   localparam logic [7:0] OFS_STATE   = 8'h04;
   localparam logic [7:0] OFS_CYCLES  = 8'h08;
   localparam logic [7:0] OFS_PULSES  = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_MASK    = 8'h14;
   localparam logic [7:0] OFS_NOTCHED = 8'h18;
   localparam logic [7:0] OFS_UNFILT  = 8'h1c;

   // Command codes written to the command register.
   localparam logic [7:0] CMD_FREQ    = 8'h01;  // Count audio frequency.
   localparam logic [7:0] CMD_DISTN   = 8'h02;  // Distortion measure.
   localparam logic [7:0] CMD_SINAD   = 8'h03;  // Special setting 29.0.
   localparam logic [7:0] CMD_EXTLVL  = 8'h04;  // Special setting 30.0.
   localparam logic [7:0] CMD_AIN_ON  = 8'h10;  // External audio input.
   localparam logic [7:0] CMD_AIN_OFF = 8'h11;  // Modulation output.
   localparam logic [7:0] CMD_NOTCH_H = 8'h20;  // 1 kHz fundamental.
   localparam logic [7:0] CMD_NOTCH_L = 8'h21;  // 400 Hz fundamental.
   localparam logic [7:0] CMD_LIN     = 8'h30;
   localparam logic [7:0] CMD_LOG     = 8'h31;
   localparam logic [7:0] CMD_RES_NRM = 8'h40;  // Special setting 32.0.
   localparam logic [7:0] CMD_RES_FIN = 8'h41;  // Special setting 32.1.
   localparam logic [7:0] CMD_RES_QRY = 8'h42;  // Special setting 32.2.
   localparam logic [7:0] CMD_WATTS   = 8'h50;  // Watts unit request.
   localparam logic [7:0] CMD_OTHUNIT = 8'h51;  // Volt-type unit request.
   localparam logic [7:0] CMD_DET_OTH = 8'h60;  // Non-rms detector request.
   localparam logic [7:0] CMD_DET_RMS = 8'h61;

   // Status and mask bit positions.
   localparam int unsigned ST_DONE  = 0;
   localparam int unsigned ST_ERR   = 1;
   localparam int unsigned ST_DIST  = 2;
   localparam int unsigned ST_BADC  = 3;
   localparam int unsigned ST_W     = 4;

   // State register bit positions.
   localparam int unsigned SB_MODE   = 0;   // Two bits.
   localparam int unsigned SB_EXT    = 2;
   localparam int unsigned SB_CONN   = 3;
   localparam int unsigned SB_NOTCH  = 4;
   localparam int unsigned SB_LOG    = 5;
   localparam int unsigned SB_FINE   = 6;
   localparam int unsigned SB_RMS    = 7;
   localparam int unsigned SB_PRED   = 8;
   localparam int unsigned SB_QRY    = 9;
   localparam int unsigned SB_DSTEP  = 10;
   localparam int unsigned SB_BUSY   = 11;

   typedef enum logic [1:0] {ARC_M_FREQ, ARC_M_DISTN, ARC_M_SINAD, ARC_M_LEVEL} arc_mode_t;
   typedef enum {ARC_G_IDLE, ARC_G_ARM, ARC_G_RUN, ARC_G_CLOSE} arc_gate_t;
   typedef enum {ARC_D_IDLE, ARC_D_UNF, ARC_D_NOTCH, ARC_D_DONE} arc_dist_t;
endpackage : arc_pkg

/* core/arc_ctl.sv */
// Purpose: Reciprocal audio counter and audio measurement command control.
// Assumes: One 10 MHz clock, APB register access, analog readings arrive with strobes.
// Notes:   The arithmetic of the reciprocal equation is left to software;
//          the block delivers exact cycle and pulse counts.
// Notes on behaviour
// - Timebase counted inside gate, at least 100 ms
// - Frequency is cycles times 10 MHz over pulses
// - 100 ms gate gives six-digit resolution
// - External input selects counter source and connector
// - Counts audio from 20 Hz to 250 kHz
// - Fine option sets 0.1 Hz above 100 kHz
// - Fine option gives 0.001 dB display
// - Fine option setting survives power loss
// - Resolution query reports 0 or 1
// - Decoder selects distortion and external input
// - Notch fundamental stored and reapplied
// - Distortion: unfiltered first, then notched ratio
// - Distortion or level selects rms and pre-display
// - External level forces connector to input
// - Watts for audio level flags an error
// - SINAD reports reciprocal of distortion
// - Linear or log choice remembered and restored
// - External distortion allows only rms detector; a non-rms choice made before CMD_AIN_ON stays selected
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module arc_ctl
   import arc_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        AUDIO_INT,       // Conditioned internal demodulated audio.
   input  wire logic        AUDIO_EXT,       // Conditioned external audio from connector.
   input  wire logic        NV_FINE,         // Stored fine-resolution bit at power up.
   input  wire logic        RMS_VALID,       // Strobe: an rms reading is ready.
   input  wire logic [31:0] RMS_VALUE,
   output logic             NV_WRITE,        // Pulse: store NV_DATA in nonvolatile cell.
   output logic             NV_DATA,
   output logic             CONN_IS_INPUT,
   output logic             NOTCH_IN,        // Route path through the notch.
   output logic             NOTCH_LOW,       // Notch tuned to 400 Hz when high.
   output logic             RMS_DET,
   output logic             PRE_DISPLAY,
   output logic             LOG_UNITS,
   output logic             FINE_RES,
   output logic             SINAD_MODE,
   output logic             IRQ
);
   logic [2:0]        ai_sync_q;
   logic [2:0]        ae_sync_q;
   logic [2:0]        nv_sync_q;
   logic              ai_lvl_q, ae_lvl_q, src_prev_q;
   arc_mode_t         mode_q;
   logic              ext_q, notch_low_q, log_q, fine_q, rms_q, pred_q, query_q;
   logic              fine_loaded_q;
   logic [2:0]        nv_fill_q;
   arc_gate_t         gate_q;
   arc_dist_t         dist_q;
   logic [CNT_W-1:0]  tb_cnt_q, cyc_cnt_q, tb_res_q, cyc_res_q;
   logic [31:0]       unf_q, notched_q;
   logic [ST_W-1:0]   status_q, mask_q, ev_set;
   logic              src_lvl, src_rise, start_gate, bus_wr, bus_rd, cmd_wr;
   logic [7:0]        cmd;
   logic              sel_distn, sel_sinad, sel_level, ev_done, ev_err, ev_dist, ev_badc;

   // Address recognised by this slave.
   function automatic logic arc_mapped(input logic [7:0] a);
      arc_mapped = (a <= OFS_UNFILT) && (a[1:0] == 2'b00);
   endfunction : arc_mapped

   assign bus_wr = PSEL && PENABLE && PWRITE && arc_mapped(PADDR);
   assign bus_rd = PSEL && PENABLE && !PWRITE && arc_mapped(PADDR);
   assign cmd_wr = bus_wr && (PADDR == OFS_CMD);
   assign cmd    = PWDATA[7:0];
   assign sel_distn = cmd_wr && (cmd == CMD_DISTN);
   assign sel_sinad = cmd_wr && (cmd == CMD_SINAD);
   assign sel_level = cmd_wr && (cmd == CMD_EXTLVL);

   // Three-stage synchronisers; an audio change counts once stages two and three agree.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ai_sync_q <= 3'h0;
         ae_sync_q <= 3'h0;
         nv_sync_q <= 3'h0;
         ai_lvl_q  <= 1'b0;
         ae_lvl_q  <= 1'b0;
      end
      else
      begin
         ai_sync_q <= {ai_sync_q[1:0], AUDIO_INT};
         ae_sync_q <= {ae_sync_q[1:0], AUDIO_EXT};
         nv_sync_q <= {nv_sync_q[1:0], NV_FINE};
         if (ai_sync_q[1] == ai_sync_q[2]) ai_lvl_q <= ai_sync_q[2];
         if (ae_sync_q[1] == ae_sync_q[2]) ae_lvl_q <= ae_sync_q[2];
      end
   end

   assign src_lvl  = ext_q ? ae_lvl_q : ai_lvl_q;
   assign src_rise = src_lvl && !src_prev_q;
   assign start_gate = cmd_wr && (cmd == CMD_FREQ);

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N) src_prev_q <= 1'b0;
      else          src_prev_q <= src_lvl;
   end

   // Gate machine. Rising source edges open it and, once GATE_MIN_CYC clocks have passed, close it, so a whole number
   // of audio cycles is counted; at GATE_MAX_CYC clocks without a closing edge the gate closes anyway, and an empty count is flagged as an error.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         gate_q    <= ARC_G_IDLE;
         tb_cnt_q  <= '0;
         cyc_cnt_q <= '0;
         tb_res_q  <= '0;
         cyc_res_q <= '0;
      end
      else
      begin
         case (gate_q)
            ARC_G_IDLE:
            begin
               if (start_gate) gate_q <= ARC_G_ARM;
            end
            ARC_G_ARM:
            begin
               tb_cnt_q  <= '0;
               cyc_cnt_q <= '0;
               if (src_rise) gate_q <= ARC_G_RUN;
               else if (tb_cnt_q >= CNT_W'(GATE_MAX_CYC)) gate_q <= ARC_G_CLOSE;
               else tb_cnt_q <= tb_cnt_q + 1'b1;
            end
            ARC_G_RUN:
            begin
               tb_cnt_q <= tb_cnt_q + 1'b1;
               if (src_rise) cyc_cnt_q <= cyc_cnt_q + 1'b1;
               if (src_rise && (tb_cnt_q + 1'b1 >= CNT_W'(GATE_MIN_CYC)))
                  gate_q <= ARC_G_CLOSE;
               else if (tb_cnt_q >= CNT_W'(GATE_MAX_CYC))
                  gate_q <= ARC_G_CLOSE;
            end
            ARC_G_CLOSE:
            begin
               tb_res_q  <= tb_cnt_q;
               cyc_res_q <= cyc_cnt_q;
               gate_q    <= ARC_G_IDLE;
            end
            default: gate_q <= ARC_G_IDLE;
         endcase
      end
   end

   // range check: zero cycles or above 250 kHz is flagged.
   assign ev_done = (gate_q == ARC_G_CLOSE) && (cyc_cnt_q != '0);
   assign ev_badc = (gate_q == ARC_G_CLOSE) &&
                    ((cyc_cnt_q == '0) ||
                     (cyc_cnt_q > CNT_W'(MAX_AUDIO_HZ / 1000 * GATE_MIN_MS)));

   // Mode, remembered settings and detector choices from the command decoder.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q      <= ARC_M_FREQ;
         ext_q       <= 1'b0;
         notch_low_q <= 1'b0;
         log_q       <= 1'b0;
         rms_q       <= 1'b0;
         pred_q      <= 1'b0;
      end
      else if (cmd_wr)
      begin
         case (cmd)
            CMD_FREQ:    mode_q <= ARC_M_FREQ;
            CMD_DISTN:   mode_q <= ARC_M_DISTN;
            CMD_SINAD:   mode_q <= ARC_M_SINAD;
            CMD_EXTLVL:  mode_q <= ARC_M_LEVEL;
            CMD_AIN_ON:  ext_q <= 1'b1;
            CMD_AIN_OFF: ext_q <= 1'b0;
            CMD_NOTCH_H: notch_low_q <= 1'b0;
            CMD_NOTCH_L: notch_low_q <= 1'b1;
            CMD_LIN:     log_q <= 1'b0;
            CMD_LOG:     log_q <= 1'b1;
            CMD_DET_RMS: rms_q <= 1'b1;
            CMD_DET_OTH: if (!(ext_q && mode_q != ARC_M_FREQ)) rms_q <= 1'b0;
            default: ;
         endcase
         if (cmd == CMD_DISTN || cmd == CMD_EXTLVL || cmd == CMD_SINAD)
         begin
            rms_q  <= 1'b1;
            pred_q <= 1'b1;
         end
      end
   end

   assign ev_err = cmd_wr && ((cmd == CMD_WATTS && mode_q == ARC_M_LEVEL) ||
                   (cmd == CMD_DET_OTH && ext_q && mode_q != ARC_M_FREQ));

   // Fine resolution: loaded once from the nonvolatile cell after reset, and
   // every change is written back so it survives power down.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         fine_q        <= 1'b0;
         fine_loaded_q <= 1'b0;
         nv_fill_q     <= 3'h0;
         query_q       <= 1'b0;
         NV_WRITE      <= 1'b0;
         NV_DATA       <= 1'b0;
      end
      else
      begin
         NV_WRITE <= 1'b0;
         // The stored bit is taken only once it has crossed all three stages.
         nv_fill_q <= {nv_fill_q[1:0], 1'b1};
         if (!fine_loaded_q)
         begin
            if (nv_fill_q[2])
            begin
               fine_q        <= nv_sync_q[2];
               fine_loaded_q <= 1'b1;
            end
         end
         else if (cmd_wr && (cmd == CMD_RES_NRM || cmd == CMD_RES_FIN))
         begin
            fine_q   <= (cmd == CMD_RES_FIN);
            NV_WRITE <= 1'b1;
            NV_DATA  <= (cmd == CMD_RES_FIN);
         end
         if (cmd_wr && cmd == CMD_RES_QRY) query_q <= fine_q;
      end
   end

   // Distortion sequence: unfiltered reading, then notched reading.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         dist_q    <= ARC_D_IDLE;
         unf_q     <= '0;
         notched_q <= '0;
      end
      else
      begin
         case (dist_q)
            ARC_D_IDLE:
               if (sel_distn || sel_sinad) dist_q <= ARC_D_UNF;
            ARC_D_UNF:
               if (RMS_VALID)
               begin
                  unf_q  <= RMS_VALUE;
                  dist_q <= ARC_D_NOTCH;
               end
            ARC_D_NOTCH:
               if (RMS_VALID)
               begin
                  notched_q <= RMS_VALUE;
                  dist_q    <= ARC_D_DONE;
               end
            ARC_D_DONE:
               dist_q <= (mode_q == ARC_M_DISTN || mode_q == ARC_M_SINAD) ?
                         ARC_D_UNF : ARC_D_IDLE;
            default: dist_q <= ARC_D_IDLE;
         endcase
         if (cmd_wr && !(sel_distn || sel_sinad) && cmd < CMD_AIN_ON) dist_q <= ARC_D_IDLE;
      end
   end
   assign ev_dist = (dist_q == ARC_D_DONE);

   // Registered control outputs.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         CONN_IS_INPUT <= 1'b0;
         NOTCH_IN      <= 1'b0;
         NOTCH_LOW     <= 1'b0;
         RMS_DET       <= 1'b0;
         PRE_DISPLAY   <= 1'b0;
         LOG_UNITS     <= 1'b0;
         FINE_RES      <= 1'b0;
         SINAD_MODE    <= 1'b0;
      end
      else
      begin
         CONN_IS_INPUT <= ext_q || (mode_q == ARC_M_LEVEL);
         NOTCH_IN      <= (dist_q == ARC_D_NOTCH);
         NOTCH_LOW     <= notch_low_q;
         RMS_DET       <= rms_q;
         PRE_DISPLAY   <= pred_q;
         LOG_UNITS     <= log_q;
         FINE_RES      <= fine_q;
         SINAD_MODE    <= (mode_q == ARC_M_SINAD);
      end
   end

   // Sticky status; the set wins over the read-clear in the same cycle.
   assign ev_set = {ev_badc, ev_dist, ev_err, ev_done};
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         status_q <= '0;
         mask_q   <= '0;
         IRQ      <= 1'b0;
      end
      else
      begin
         if (bus_rd && PADDR == OFS_STATUS) status_q <= ev_set;
         else                               status_q <= status_q | ev_set;
         if (bus_wr && PADDR == OFS_MASK) mask_q <= PWDATA[ST_W-1:0];
         IRQ <= |(status_q & mask_q);
      end
   end

   // APB slave: answers in the access cycle; unmapped addresses get PSLVERR.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !arc_mapped(PADDR);
         PRDATA  <= '0;
         if (PSEL && !PENABLE && !PWRITE)
         begin
            if (PADDR == OFS_STATE)
               PRDATA <= {20'h0, (gate_q != ARC_G_IDLE), (dist_q == ARC_D_NOTCH), query_q,
                          pred_q, rms_q, fine_q, log_q, notch_low_q,
                          (ext_q || mode_q == ARC_M_LEVEL), ext_q, mode_q};
            else if (PADDR == OFS_CYCLES)  PRDATA <= cyc_res_q;
            else if (PADDR == OFS_PULSES)  PRDATA <= tb_res_q;
            else if (PADDR == OFS_STATUS)  PRDATA <= {28'h0, status_q | ev_set};
            else if (PADDR == OFS_MASK)    PRDATA <= {28'h0, mask_q};
            else if (PADDR == OFS_NOTCHED) PRDATA <= notched_q;
            else if (PADDR == OFS_UNFILT)  PRDATA <= unf_q;
            else                           PRDATA <= '0;
         end
      end
   end

   property p_gate_open;
      @(posedge CLOCK) disable iff (!RESET_N)
      (gate_q == ARC_G_ARM && src_rise) |=> (gate_q == ARC_G_RUN && tb_cnt_q == '0);
   endproperty
   a_gate_open: assert property (p_gate_open) else $error("Gate did not open on edge.");
   property p_close_min;
      @(posedge CLOCK) disable iff (!RESET_N)
      (gate_q == ARC_G_CLOSE && cyc_cnt_q != '0) |-> tb_cnt_q >= CNT_W'(GATE_MIN_CYC);
   endproperty
   a_close_min: assert property (p_close_min) else $error("Gate closed early.");
   property p_level_conn;
      @(posedge CLOCK) disable iff (!RESET_N)
      (mode_q == ARC_M_LEVEL) |=> CONN_IS_INPUT;
   endproperty
   a_level_conn: assert property (p_level_conn) else $error("Level mode lacks input.");
   property p_distn_rms;
      @(posedge CLOCK) disable iff (!RESET_N)
      sel_distn |=> rms_q && pred_q ##1 RMS_DET && PRE_DISPLAY;
   endproperty
   a_distn_rms: assert property (p_distn_rms) else $error("Rms not selected.");
   property p_watts_err;
      @(posedge CLOCK) disable iff (!RESET_N)
      (cmd_wr && cmd == CMD_WATTS && mode_q == ARC_M_LEVEL) |=> status_q[ST_ERR];
   endproperty
   a_watts_err: assert property (p_watts_err) else $error("Watts not flagged.");
   property p_ext_rms;
      @(posedge CLOCK) disable iff (!RESET_N)
      (ext_q && mode_q == ARC_M_DISTN && rms_q) |=> rms_q;
   endproperty
   a_ext_rms: assert property (p_ext_rms) else $error("Detector left rms.");
   property p_nv_wr;
      @(posedge CLOCK) disable iff (!RESET_N)
      NV_WRITE |-> NV_DATA == fine_q;
   endproperty
   a_nv_wr: assert property (p_nv_wr) else $error("Stored bit mismatch.");
   sequence s_unf;
      dist_q == ARC_D_UNF && RMS_VALID;
   endsequence
   property p_order;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_unf |=> dist_q == ARC_D_NOTCH ##1 NOTCH_IN;
   endproperty
   a_order: assert property (p_order) else $error("Notch step out of order.");
   property p_sinad;
      @(posedge CLOCK) disable iff (!RESET_N)
      sel_sinad |=> ##1 SINAD_MODE;
   endproperty
   a_sinad: assert property (p_sinad) else $error("Sinad flag missing.");
   property p_irq;
      @(posedge CLOCK) disable iff (!RESET_N)
      |(status_q & mask_q) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt missing.");
endmodule : arc_ctl
`default_nettype wire

/* tb/arc_far.sv */
// Purpose: Far-side model: audio sources, rms readings and the stored fine bit.
// Assumes: Values change by non-blocking assignment just after rising edges.
// Notes:   Audio runs free; the two tones differ in rate so a wrong source shows.
`timescale 1ns/1ns
`default_nettype none
module arc_far
(
   input  wire logic        CLOCK,
   output logic             AUDIO_INT,
   output logic             AUDIO_EXT,
   output logic             NV_FINE,
   output logic             RMS_VALID,
   output logic [31:0]      RMS_VALUE
);
   logic [7:0] ph_q;

   initial
   begin
      ph_q      = 8'h00;
      AUDIO_INT = 1'b0;
      AUDIO_EXT = 1'b0;
      NV_FINE   = 1'b0;
      RMS_VALID = 1'b0;
      RMS_VALUE = 32'h0;
   end

   // Square waves of period 32 and 128 clocks.
   always @(posedge CLOCK)
   begin
      ph_q      <= ph_q + 8'h01;
      AUDIO_INT <= ph_q[4];
      AUDIO_EXT <= ph_q[6];
   end

   // One reading strobe; stale data is inverted so it cannot pass for fresh.
   task automatic send_rms(input logic [31:0] v);
      @(posedge CLOCK);
      RMS_VALID <= 1'b1;
      RMS_VALUE <= v;
      @(posedge CLOCK);
      RMS_VALID <= 1'b0;
      RMS_VALUE <= ~v;
   endtask : send_rms
endmodule : arc_far
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the audio counter control block.
// Assumes: APB master with registered answers; 10 MHz clock.
// Notes:   A full 100 ms gate is too long to run; only its opening is seen.
`timescale 1ns/1ns
`default_nettype none
module tb
   import arc_pkg::*;
;
   logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rms_value;
   logic pready, pslverr, er, a_int, a_ext, nv_fine, rms_valid, nv_write, nv_data;
   logic conn, n_in, n_low, rms_det, pre_d, log_u, fine, sinad, irq;
   logic nv_seen = 1'b0, nv_val = 1'b0;
   int miscompares = 0, n_tests = 0, cyc = 0;

   always #50 clock = ~clock;

   arc_far arc_far_i (.CLOCK(clock), .AUDIO_INT(a_int), .AUDIO_EXT(a_ext), .NV_FINE(nv_fine),
      .RMS_VALID(rms_valid), .RMS_VALUE(rms_value));
   arc_ctl arc_ctl_i (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .AUDIO_INT(a_int), .AUDIO_EXT(a_ext), .NV_FINE(nv_fine),
      .RMS_VALID(rms_valid), .RMS_VALUE(rms_value), .NV_WRITE(nv_write), .NV_DATA(nv_data),
      .CONN_IS_INPUT(conn), .NOTCH_IN(n_in), .NOTCH_LOW(n_low), .RMS_DET(rms_det),
      .PRE_DISPLAY(pre_d), .LOG_UNITS(log_u), .FINE_RES(fine), .SINAD_MODE(sinad), .IRQ(irq));

   // The store strobe lasts one cycle, so it is caught here; also the hang limit.
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (nv_write === 1'b1) begin nv_seen <= 1'b1; nv_val <= nv_data; end
      if (cyc == 30000) begin miscompares++; end_of_test(); end
   end

   task automatic end_of_test();
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Setup, access until ready, release, then one idle edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic cmd(input logic [7:0] c);
      apb(1'b1, OFS_CMD, {24'h0, c});
      repeat (2) @(posedge clock);
   endtask : cmd

   task automatic rbit(input logic [7:0] a, input int b);
      apb(1'b0, a, 32'h0);
      rd = {31'h0, rd[b]};
   endtask : rbit

   // Reset state and refused addresses.
   task automatic t_reset();
      apb(1'b0, OFS_STATE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_CYCLES, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_PULSES, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, 8'h02, 32'h0);
      chk(er, 1'b1);
   endtask : t_reset

   task automatic t_dist();
      apb(1'b1, OFS_MASK, 32'h1 << ST_DIST);
      cmd(CMD_DISTN);
      chk({rms_det, pre_d, n_in}, 3'b110);
      arc_far_i.send_rms(32'h0000_1111);
      repeat (3) @(posedge clock);
      chk(n_in, 1'b1);
      arc_far_i.send_rms(32'h0000_0022);
      repeat (3) @(posedge clock);
      chk(irq, 1'b1);
      apb(1'b0, OFS_UNFILT, 32'h0);
      chk(rd, 32'h0000_1111);
      apb(1'b0, OFS_NOTCHED, 32'h0);
      chk(rd, 32'h0000_0022);
      rbit(OFS_STATUS, ST_DIST);
      chk(rd, 32'h1);
      repeat (2) @(posedge clock);
      chk(irq, 1'b0);
   endtask : t_dist

   // gate opens; notch and units restored.
   task automatic t_recall();
      cmd(CMD_NOTCH_L);
      cmd(CMD_LOG);
      cmd(CMD_FREQ);
      repeat (80) @(posedge clock);
      rbit(OFS_STATE, SB_BUSY);
      chk(rd, 32'h1);
      cmd(CMD_DISTN);
      chk({n_low, log_u}, 2'b11);
      cmd(CMD_LIN);
      cmd(CMD_NOTCH_H);
      chk({n_low, log_u}, 2'b00);
   endtask : t_recall

   task automatic t_conn();
      cmd(CMD_AIN_ON);
      chk(conn, 1'b1);
      cmd(CMD_DET_OTH);
      chk(rms_det, 1'b1);
      cmd(CMD_AIN_OFF);
      chk(conn, 1'b0);
      cmd(CMD_EXTLVL);
      chk(conn, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      cmd(CMD_WATTS);
      rbit(OFS_STATUS, ST_ERR);
      chk(rd, 32'h1);
      cmd(CMD_OTHUNIT);
      rbit(OFS_STATUS, ST_ERR);
      chk(rd, 32'h0);
      cmd(CMD_SINAD);
      chk(sinad, 1'b1);
   endtask : t_conn

   task automatic t_fine();
      cmd(CMD_RES_FIN);
      chk({fine, nv_seen, nv_val}, 3'b111);
      cmd(CMD_RES_QRY);
      rbit(OFS_STATE, SB_QRY);
      chk(rd, 32'h1);
      cmd(CMD_RES_NRM);
      cmd(CMD_RES_QRY);
      rbit(OFS_STATE, SB_QRY);
      chk({rd[0], fine, nv_val}, 3'b000);
   endtask : t_fine

   initial
   begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_dist();
      t_recall();
      t_conn();
      t_fine();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
